// ===== hdl/sirl_core.sv
`include "sirl_map.svh"
module sirl_core #(
   parameter int LEVELS = 8
) (
   input  wire logic                clock,
   input  wire logic                srst,
   input  wire logic                clk_en,
   input  wire sirl_pkg::sirl_bus_t bus,
   output logic [7:0]               rdata,
   input  wire logic [LEVELS-1:0]   hw_event,
   input  wire logic                vec_ack,
   output sirl_pkg::sirl_vec_t      vec,
   output logic                     irq
);
   initial begin
      if (LEVELS != 8) $error("LEVELS must be 8 for an 8-bit request register");
   end

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   logic [7:0]            interrupt_request_reg;
   logic [7:0]            interrupt_level_mask_reg;
   logic                  gie;
   logic [7:0]            rdata_q;
   logic [`SIRL_EV_W-1:0] ev_stat;
   logic [`SIRL_EV_W-1:0] ev_mask;
   sirl_pkg::sirl_state_t state;
   sirl_pkg::sirl_vec_t   vec_q;

   logic [7:0]            next_req;
   logic [7:0]            next_mask;
   logic                  next_gie;
   logic [7:0]            next_rdata;
   logic [`SIRL_EV_W-1:0] next_ev_stat;
   logic [`SIRL_EV_W-1:0] next_ev_mask;
   sirl_pkg::sirl_state_t next_state;
   sirl_pkg::sirl_vec_t   next_vec;

   logic [7:0]            eligible;
   logic                  any_elig;
   logic [2:0]            top_level;
   logic [`SIRL_EV_W-1:0] ev_set;

   function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
      return bus.wr && (a == b);
   endfunction

   // -----------------------------------------------------------------
   // Priority select
   // -----------------------------------------------------------------
   assign eligible = gie ? (interrupt_request_reg & interrupt_level_mask_reg) : 8'h00;

   sirl_prio #(.LEVELS(LEVELS)) u_prio (
      .pending (eligible),
      .any     (any_elig),
      .level   (top_level)
   );

   // -----------------------------------------------------------------
   // Next values
   // -----------------------------------------------------------------
   always_comb begin
      next_req     = interrupt_request_reg | hw_event;
      next_mask    = interrupt_level_mask_reg;
      next_gie     = gie;
      next_state   = state;
      next_vec     = vec_q;
      ev_set       = '0;
      next_ev_mask = ev_mask;
      next_rdata   = 8'h00;

      // Dispatch handshake
      case (state)
         sirl_pkg::SIRL_IDLE: begin
            if (any_elig) begin
               next_vec.valid = 1'b1;
               next_vec.level = top_level;
               next_state     = sirl_pkg::SIRL_WAIT;
               ev_set[`SIRL_EV_DISPATCH] = 1'b1;
            end
         end
         sirl_pkg::SIRL_WAIT: begin
            if (vec_ack) begin
               next_req[vec_q.level] = 1'b0;
               next_vec.valid        = 1'b0;
               next_state            = sirl_pkg::SIRL_HOLD;
            end
         end
         sirl_pkg::SIRL_HOLD: begin
            next_state = sirl_pkg::SIRL_IDLE;
         end
         default: begin
            next_state = sirl_pkg::SIRL_IDLE;
         end
      endcase

      // Software write replaces request contents
      if (hit(bus.addr, `SIRL_ADDR_REQ)) begin
         next_req = bus.wdata;
         if ((hw_event & ~interrupt_request_reg & ~bus.wdata) != 8'h00) begin
            ev_set[`SIRL_EV_LOST] = 1'b1;
         end
      end
      if (hit(bus.addr, `SIRL_ADDR_MASK)) begin
         next_mask = bus.wdata;
      end
      if (hit(bus.addr, `SIRL_ADDR_CTRL)) begin
         next_gie = bus.wdata[`SIRL_CTRL_GIE];
      end
      if (hit(bus.addr, `SIRL_ADDR_EVMASK)) begin
         next_ev_mask = bus.wdata[`SIRL_EV_W-1:0];
      end

      // Sticky status, set wins over write-one-clear
      next_ev_stat = ev_stat;
      if (hit(bus.addr, `SIRL_ADDR_STAT)) begin
         next_ev_stat = ev_stat & ~bus.wdata[`SIRL_EV_W-1:0];
      end
      next_ev_stat = next_ev_stat | ev_set;

      // Read mux
      if (bus.rd) begin
         case (bus.addr)
            `SIRL_ADDR_REQ:   next_rdata = interrupt_request_reg;
            `SIRL_ADDR_MASK:  next_rdata = interrupt_level_mask_reg;
            `SIRL_ADDR_CTRL:  next_rdata = {7'h00, gie};
            `SIRL_ADDR_VEC:   next_rdata = {4'h0, vec_q.valid, vec_q.level};
            `SIRL_ADDR_STAT:  next_rdata = {6'h00, ev_stat};
            `SIRL_ADDR_EVMASK: next_rdata = {6'h00, ev_mask};
            default:          next_rdata = 8'h00;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (srst) begin
         interrupt_request_reg    <= `SIRL_REQ_RST;
         interrupt_level_mask_reg <= `SIRL_MASK_RST;
         gie                      <= 1'b0;
         rdata_q                  <= 8'h00;
         ev_stat                  <= '0;
         ev_mask                  <= '0;
         state                    <= sirl_pkg::SIRL_IDLE;
         vec_q                    <= '0;
      end else if (clk_en) begin
         interrupt_request_reg    <= next_req;
         interrupt_level_mask_reg <= next_mask;
         gie                      <= next_gie;
         rdata_q                  <= next_rdata;
         ev_stat                  <= next_ev_stat;
         ev_mask                  <= next_ev_mask;
         state                    <= next_state;
         vec_q                    <= next_vec;
      end
   end

   assign rdata = rdata_q;
   assign vec   = vec_q;
   assign irq   = |(ev_stat & ev_mask);

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   a_write_stores: assert property (@(posedge clock) disable iff (srst)
      clk_en && bus.wr && bus.addr == `SIRL_ADDR_REQ |=> interrupt_request_reg == $past(bus.wdata))
      else $error("request write not stored");

   a_write_wins_hw: assert property (@(posedge clock) disable iff (srst)
      clk_en && bus.wr && bus.addr == `SIRL_ADDR_REQ && hw_event != 8'h00
      |=> (interrupt_request_reg & ~$past(bus.wdata)) == 8'h00)
      else $error("hardware event survived a request write");

   a_hw_sets_bit: assert property (@(posedge clock) disable iff (srst)
      clk_en && !bus.wr && state != sirl_pkg::SIRL_WAIT
      |=> (interrupt_request_reg & $past(hw_event | interrupt_request_reg))
          == $past(hw_event | interrupt_request_reg))
      else $error("request bit lost without clear");

   a_dispatch_gated: assert property (@(posedge clock) disable iff (srst)
      $rose(vec.valid) |-> $past(gie) &&
      (($past(interrupt_request_reg & interrupt_level_mask_reg) >> vec.level) & 8'h01) == 8'h01)
      else $error("dispatch without enable and mask");

   a_dispatch_top: assert property (@(posedge clock) disable iff (srst)
      $rose(vec.valid) |-> ($past(eligible) >> vec.level) == 8'h01)
      else $error("dispatch of a lower level");

   a_dispatch_soon: assert property (@(posedge clock) disable iff (srst)
      clk_en && state == sirl_pkg::SIRL_IDLE && eligible != 8'h00 |=> vec.valid)
      else $error("eligible request not dispatched");

   a_reset_clear: assert property (@(posedge clock)
      srst |=> interrupt_request_reg == 8'h00 && interrupt_level_mask_reg == 8'h00)
      else $error("reset did not clear registers");

   a_mask_blocks: assert property (@(posedge clock) disable iff (srst)
      !gie && state == sirl_pkg::SIRL_IDLE |=> !$rose(vec.valid))
      else $error("dispatch while disabled");

   a_ack_clears: assert property (@(posedge clock) disable iff (srst)
      clk_en && state == sirl_pkg::SIRL_WAIT && vec_ack
      && !(bus.wr && bus.addr == `SIRL_ADDR_REQ)
      |=> ((interrupt_request_reg >> $past(vec_q.level)) & 8'h01) == 8'h00)
      else $error("acknowledged request not cleared");

   a_valid_holds: assert property (@(posedge clock) disable iff (srst)
      vec.valid && !vec_ack |=> vec.valid && $stable(vec.level))
      else $error("vector dropped before acknowledge");

   a_masked_quiet: assert property (@(posedge clock) disable iff (srst)
      state == sirl_pkg::SIRL_IDLE && eligible == 8'h00 |=> !vec.valid)
      else $error("dispatch without eligible request");

   a_mask_stores: assert property (@(posedge clock) disable iff (srst)
      clk_en && bus.wr && bus.addr == `SIRL_ADDR_MASK
      |=> interrupt_level_mask_reg == $past(bus.wdata))
      else $error("level mask write not stored");

   a_lost_flag: assert property (@(posedge clock) disable iff (srst)
      clk_en && bus.wr && bus.addr == `SIRL_ADDR_REQ
      && (hw_event & ~interrupt_request_reg & ~bus.wdata) != 8'h00
      |=> ev_stat[`SIRL_EV_LOST])
      else $error("lost hardware request not flagged");

   a_reset_quiet: assert property (@(posedge clock)
      srst |=> !vec.valid && state == sirl_pkg::SIRL_IDLE && !irq)
      else $error("reset left a dispatch pending");

   a_freeze_hold: assert property (@(posedge clock) disable iff (srst)
      !clk_en |=> $stable(interrupt_request_reg) && $stable(vec) && $stable(rdata))
      else $error("state changed while clock enable low");
endmodule // sirl_core

// ===== hdl/sirl_map.svh
`ifndef SIRL_MAP_SVH
`define SIRL_MAP_SVH
// Contract
// - A CPU register-file write that targets the request register stores into it while clk_en is high.
// - Software-set request bits go through the same level mask and dispatch as hardware ones.
// - A level is dispatched only when globally enabled, its mask set, and no higher unmasked level pending.
// - Software writes to the request register are accepted in any dispatch state while clk_en is high.
// - A software write in the same cycle as a hardware set replaces the register wholesale.
// - Reset clears both the level mask register and the request register to zero.

// -----------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------
`define SIRL_ADDR_REQ     4'h0
`define SIRL_ADDR_MASK    4'h1
`define SIRL_ADDR_CTRL    4'h2
`define SIRL_ADDR_VEC     4'h3
`define SIRL_ADDR_STAT    4'h4
`define SIRL_ADDR_EVMASK  4'h5

// -----------------------------------------------------------------
// Fields and reset values
// -----------------------------------------------------------------
`define SIRL_CTRL_GIE     0
`define SIRL_REQ_RST      8'h00
`define SIRL_MASK_RST     8'h00
`define SIRL_EV_DISPATCH  0
`define SIRL_EV_LOST      1
`define SIRL_EV_W         2
`endif

// ===== hdl/sirl_pkg.sv
package sirl_pkg;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } sirl_bus_t;

   typedef struct packed {
      logic       valid;
      logic [2:0] level;
   } sirl_vec_t;

   typedef enum logic [1:0] {
      SIRL_IDLE = 2'b00,
      SIRL_WAIT = 2'b01,
      SIRL_HOLD = 2'b11
   } sirl_state_t;
endpackage

// ===== hdl/sirl_prio.sv
`include "sirl_map.svh"
module sirl_prio #(
   parameter int LEVELS = 8
) (
   input  wire logic [LEVELS-1:0]         pending,
   output logic                           any,
   output logic [$clog2(LEVELS)-1:0]      level
);
   initial begin
      if (LEVELS < 2 || LEVELS > 8) $error("LEVELS must be 2..8");
   end

   // Highest bit index wins
   always_comb begin
      any   = 1'b0;
      level = '0;
      for (int i = 0; i < LEVELS; i++) begin
         if (pending[i]) begin
            any   = 1'b1;
            level = i[$clog2(LEVELS)-1:0];
         end
      end
   end
endmodule // sirl_prio

// ===== sim/sirl_cpu_model.sv
// ----------------------------------------
// Processor side of the dispatch link
// ----------------------------------------
module sirl_cpu_model (
   input  wire logic                clock,
   input  wire logic                srst,
   input  wire sirl_pkg::sirl_vec_t vec,
   input  wire logic [3:0]          ack_wait,
   output logic                     vec_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] count;
   // Takes each vector after ack_wait cycles, one-cycle acknowledge
   always_ff @(posedge clock) begin
      if (srst || !vec.valid || vec_ack) begin
         count   <= 4'h0;
         vec_ack <= 1'b0;
      end else if (count == ack_wait) begin
         vec_ack <= 1'b1;
      end else begin
         count <= count + 4'h1;
      end
   end
endmodule // sirl_cpu_model

// ===== sim/test_soft_interrupt_request_logic.sv
`include "sirl_map.svh"
module test_soft_interrupt_request_logic;
   timeunit 1ns;
   timeprecision 1ps;
   logic                clock;
   logic                srst;
   logic                clk_en;
   sirl_pkg::sirl_bus_t bus;
   logic [7:0]          rdata;
   logic [7:0]          hw_event;
   logic                vec_ack;
   sirl_pkg::sirl_vec_t vec;
   logic                irq;
   logic [3:0]          ack_wait;
   int                  errors;
   int                  num_checks;

   sirl_core #(.LEVELS(8)) uut (.clock(clock), .srst(srst), .clk_en(clk_en), .bus(bus),
      .rdata(rdata), .hw_event(hw_event), .vec_ack(vec_ack), .vec(vec), .irq(irq));
   sirl_cpu_model cpu (.clock(clock), .srst(srst), .vec(vec), .ack_wait(ack_wait),
      .vec_ack(vec_ack));

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // ----------------------------------------
   // Access tasks
   // ----------------------------------------
   task stop_test;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task wr(input logic [3:0] a, input logic [7:0] d, input logic [7:0] hw);
      @(posedge clock);
      bus.wr <= 1'b1;
      bus.addr <= a;
      bus.wdata <= d;
      hw_event <= hw;
      @(posedge clock);
      bus.wr <= 1'b0;
      hw_event <= 8'h00;
   endtask

   task rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clock);
      bus.rd <= 1'b1;
      bus.addr <= a;
      @(posedge clock);
      bus.rd <= 1'b0;
      #1 chk(rdata, e);
   endtask

   task wait_vec(input logic [2:0] lvl);
      int n;
      for (n = 0; n < 30 && vec.valid !== 1'b1; n++) @(posedge clock) #1;
      if (n == 30) begin
         chk(8'hFF, 8'h00);
         stop_test;
      end
      chk({5'h00, vec.level}, {5'h00, lvl});
      for (n = 0; n < 30 && vec.valid !== 1'b0; n++) @(posedge clock) #1;
      if (n == 30) begin
         chk(8'hFF, 8'h00);
         stop_test;
      end
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      errors = 0;
      num_checks = 0;
      srst = 1'b1;
      clk_en = 1'b1;
      bus = '0;
      hw_event = 8'h00;
      ack_wait = 4'h0;
      repeat (16) @(posedge clock);
      srst <= 1'b0;
      rd(`SIRL_ADDR_REQ, 8'h00);
      rd(`SIRL_ADDR_MASK, 8'h00);
      wr(4'hF, 8'h00, 8'h08);
      rd(`SIRL_ADDR_REQ, 8'h08);
      rd(4'hF, 8'h00);
      wr(`SIRL_ADDR_REQ, 8'h01, 8'h40);
      rd(`SIRL_ADDR_REQ, 8'h01);
      rd(`SIRL_ADDR_STAT, 8'h02);
      wr(`SIRL_ADDR_STAT, 8'h02, 8'h00);
      rd(`SIRL_ADDR_STAT, 8'h00);
      wr(`SIRL_ADDR_REQ, 8'h01 | 8'h20, 8'h00);
      rd(`SIRL_ADDR_REQ, 8'h21);
      wr(`SIRL_ADDR_MASK, 8'h20, 8'h00);
      wr(`SIRL_ADDR_EVMASK, 8'h01, 8'h00);
      #1 chk({7'h00, vec.valid}, 8'h00);
      wr(`SIRL_ADDR_CTRL, 8'h01, 8'h00);
      wait_vec(3'h5);
      chk({7'h00, irq}, 8'h01);
      rd(`SIRL_ADDR_REQ, 8'h01);
      chk({7'h00, vec.valid}, 8'h00);
      wr(`SIRL_ADDR_CTRL, 8'h00, 8'h00);
      wr(`SIRL_ADDR_MASK, 8'h85, 8'h00);
      wr(`SIRL_ADDR_REQ, 8'h85, 8'h00);
      repeat (3) @(posedge clock);
      ack_wait <= 4'h3;
      #1 chk({7'h00, vec.valid}, 8'h00);
      wr(`SIRL_ADDR_CTRL, 8'h01, 8'h00);
      wait_vec(3'h7);
      wait_vec(3'h2);
      wait_vec(3'h0);
      rd(`SIRL_ADDR_REQ, 8'h00);
      wr(`SIRL_ADDR_STAT, 8'h01, 8'h00);
      #1 chk({7'h00, irq}, 8'h00);
      @(posedge clock);
      clk_en <= 1'b0;
      wr(`SIRL_ADDR_REQ, 8'h10, 8'h00);
      clk_en <= 1'b1;
      rd(`SIRL_ADDR_REQ, 8'h00);
      stop_test;
   end
endmodule // test_soft_interrupt_request_logic
